/* rtl/rsh_ref_holdover_ctrl.v */
// Reference selection, holdover control, tuning word averaging and reference
// revalidation for a two-input digital PLL.
// Assumes register strobes, pins and events synchronous to clock; the tuning
// word is the loop's live word; the loop divider value comes from elsewhere.
`timescale 1ns/100ps
`include "rsh_consts.vh"

// Operation
// R1 - Policy bit 4 picks held word: 0 last tuning word, 1 averaged word.
// R2 - Automatic reference change allowed only with policy bit 2 set.
// R3 - Automatic holdover exit allowed only with policy bit 1 set.
// R4 - Automatic holdover entry allowed only with policy bit 0 set.
// R5 - Override bit 4 puts the reference mux into line card mode.
// R6 - Override bit 3 disables auto switching and ignores the select pin.
// R7 - Under reference override, bit 2: 0 first reference, 1 second.
// R8 - Override bit 1 disables auto holdover and ignores the holdover pin.
// R9 - Under holdover override, bit 0 directly sets holdover.
// R10 - Average spans two to the power of the 4-bit size field samples.
// R11 - Samples are taken at clock rate divided by two to the P.
// R12 - Software should use 32,000 or more samples and prefer averaged holdover.
// R13 - After loss or range event, wait loop period times 2^(field+1)-1.
// R14 - Validation timer counts loop filter clock periods set by P.
// R15 - Timer field zero gives the shortest, all ones the longest wait.
// R16 - Software should set validation time to two evaluation periods or more.
// R17 - Range evaluation period is reference period times its divider.
// R18 - Live status bit shows active reference: 0 first, 1 second.
// R19 - Live status bit is set while the loop is in holdover.
// R20 - Averaging keeps a sliding window so an average is always ready; until the window fills the code divides a partial sum by 2^N.
module rsh_ref_holdover_ctrl
#(
   parameter TW_W        = 48,
   parameter AVG_LOG_MAX = 15
)
(
   input  wire              clock,
   input  wire              rst_b,
   input  wire [15:0]       regAddr,
   input  wire [7:0]        regWrData,
   input  wire              regWr,
   input  wire              regRd,
   output reg  [7:0]        regRdData,
   input  wire              input_choice_pin,
   input  wire              holdoverPin,
   input  wire [3:0]        loopDivP,
   input  wire [TW_W-1:0]   tuning_word,
   input  wire              first_reference_lost_event,
   input  wire              first_out_of_range_event,
   input  wire              second_reference_lost_event,
   input  wire              second_out_of_range_event,
   output reg               activeRefSecond,
   output reg               holdoverActive,
   output reg               lineCardMode,
   output reg  [TW_W-1:0]   heldTuningWord,
   output reg               firstRefValid,
   output reg               secondRefValid
);

   // ==========================================================================
   // Registers
   // ==========================================================================
   localparam AW = AVG_LOG_MAX;
   localparam SW = TW_W + AVG_LOG_MAX;
   // Holdover state codes; the state register is the holdoverActive output itself.
   localparam ST_TRACK = 1'b0;
   localparam ST_HOLD  = 1'b1;

   reg [7:0] autoPolicy_reg;
   reg [7:0] override_reg;
   reg [7:0] avgWindow_reg;
   reg [7:0] revalTimer_reg;

   // Unused upper bits of every register are dropped on write and read back as zero.
   wire wrAuto  = regWr && (regAddr == `RSH_OFS_AUTO_POLICY);
   wire wrOvr   = regWr && (regAddr == `RSH_OFS_OVERRIDE);
   wire wrAvg   = regWr && (regAddr == `RSH_OFS_AVG_WINDOW);
   wire wrReval = regWr && (regAddr == `RSH_OFS_REVALIDATION);

   always @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         autoPolicy_reg <= `RSH_RST_AUTO_POLICY;
         override_reg   <= `RSH_RST_OVERRIDE;
         avgWindow_reg  <= `RSH_RST_AVG_WINDOW;
         revalTimer_reg <= `RSH_RST_REVALIDATION;
         lineCardMode   <= 1'b0;
      end
      else
      begin
         if (wrAuto)
            autoPolicy_reg <= {3'h0, regWrData[4:0]};
         if (wrOvr)
            override_reg <= {3'h0, regWrData[4:0]};
         if (wrAvg)
            avgWindow_reg <= {4'h0, regWrData[3:0]};
         if (wrReval)
            revalTimer_reg <= {3'h0, regWrData[4:0]};
         // The mux mode pin changes only on a clock edge, never in mid-cycle.
         lineCardMode <= override_reg[`RSH_OVR_LINE_CARD_BIT]; // [R5]
      end
   end

   // Read data stands only in the cycle after the read strobe.
   // Status words are live: they show the state at the edge that takes the read.
   reg [7:0] rdMux;
   always @*
   begin
      rdMux = 8'h00;
      case (regAddr)
         `RSH_OFS_AUTO_POLICY:  rdMux = autoPolicy_reg;
         `RSH_OFS_OVERRIDE:     rdMux = override_reg;
         `RSH_OFS_AVG_WINDOW:   rdMux = avgWindow_reg;
         `RSH_OFS_REVALIDATION: rdMux = revalTimer_reg;
         `RSH_OFS_LIVE_STATUS:
         begin
            rdMux[`RSH_STAT_REF_BIT]  = activeRefSecond; // [R18]
            rdMux[`RSH_STAT_HOLD_BIT] = holdoverActive;  // [R19]
         end
         `RSH_OFS_REF_STATUS:
         begin
            rdMux[`RSH_STAT_VALID_A_BIT] = firstRefValid;
            rdMux[`RSH_STAT_VALID_B_BIT] = secondRefValid;
         end
         default: rdMux = 8'h00;
      endcase
   end

   always @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         regRdData <= 8'h00;
      else if (regRd)
         regRdData <= rdMux;
      else
         regRdData <= 8'h00;
   end

   // ==========================================================================
   // Loop filter clock enable
   // ==========================================================================
   // One pulse every 2^P clocks; paces both sampling and validation.
   // Comparing with >= lets a smaller P take effect at once instead of after a wrap
   // of the 16-bit divider; only after P falls can the first tick come later than 2^P clocks after the last one.
   reg  [15:0] loopDiv_reg;
   wire [15:0] loopDivLast = (16'h0001 << loopDivP) - 16'h0001;
   wire        loopTick    = (loopDiv_reg >= loopDivLast);

   always @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         loopDiv_reg <= 16'h0000;
      else if (loopTick)
         loopDiv_reg <= 16'h0000; // [R11]
      else
         loopDiv_reg <= loopDiv_reg + 16'h0001;
   end

   // ==========================================================================
   // Reference revalidation timers
   // ==========================================================================
   // The shift is six bits wide so that the all-ones field still gives the longest wait.
   wire [4:0]  timerField = revalTimer_reg[`RSH_TIMER_W-1:0];
   wire [5:0]  revalShift = {1'b0, timerField} + 6'h01;
   wire [32:0] revalLimit = (33'h000000001 << revalShift) - 33'h000000001; // [R15]
   wire [1:0]  refEvent;
   wire [1:0]  refValid;
   assign refEvent[0] = first_reference_lost_event | first_out_of_range_event;   // [R17]
   assign refEvent[1] = second_reference_lost_event | second_out_of_range_event; // [R17]

   // Each reference has its own timer. An event holds the timer at zero and clears
   // validity; counting resumes on the first loop tick after the event drops, and the
   // reference is valid again after 2^(T+1)-1 ticks.
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1)
      begin : gRefVal
         reg [32:0] cnt_reg;
         reg        valid_reg;
         always @(posedge clock or negedge rst_b)
         begin
            if (!rst_b)
            begin
               cnt_reg   <= 33'h000000000;
               valid_reg <= 1'b0;
            end
            else if (refEvent[gi])
            begin
               cnt_reg   <= 33'h000000000; // [R13]
               valid_reg <= 1'b0;
            end
            else if (!valid_reg && loopTick)
            begin
               cnt_reg <= cnt_reg + 33'h000000001; // [R14]
               if ((cnt_reg + 33'h000000001) >= revalLimit)
                  valid_reg <= 1'b1; // [R13] [R15]
            end
         end
         assign refValid[gi] = valid_reg;
      end
   endgenerate

   // The valid outputs lag the internal flags by one cycle; the selector uses the flags.
   always @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         firstRefValid  <= 1'b0;
         secondRefValid <= 1'b0;
      end
      else
      begin
         firstRefValid  <= refValid[0];
         secondRefValid <= refValid[1];
      end
   end

   // ==========================================================================
   // Sliding window average of tuning words
   // ==========================================================================
   // One entry per sample of the largest window; a smaller window reads the entry
   // written 2^N ticks ago, so once full the sum covers exactly the last 2^N samples.
   reg [TW_W-1:0] avgMem [0:(1<<AW)-1];
   reg [AW-1:0]   wrPtr_reg;
   reg [AW:0]     fill_reg;
   reg [SW-1:0]   sum_reg;

   wire [3:0]    avgLog   = avgWindow_reg[`RSH_AVG_SIZE_W-1:0];
   wire [AW:0]   winSize  = {{AW{1'b0}}, 1'b1} << avgLog; // [R10]
   wire [AW-1:0] oldIdx   = wrPtr_reg - winSize[AW-1:0];
   wire [SW-1:0] newExt   = {{AVG_LOG_MAX{1'b0}}, tuning_word};
   wire [SW-1:0] oldExt   = {{AVG_LOG_MAX{1'b0}}, avgMem[oldIdx]};
   wire [SW-1:0] sumShift = sum_reg >> avgLog;
   // Until the first sample lands the live word stands in for the average.
   wire [TW_W-1:0] avgWord = (fill_reg == {(AW+1){1'b0}}) ? tuning_word : sumShift[TW_W-1:0];

   // The sample memory has no reset; only entries written since a restart are read.
   always @(posedge clock)
   begin
      if (loopTick)
         avgMem[wrPtr_reg] <= tuning_word;
   end

   // A new window size restarts the window so the sum never mixes sizes.
   // The write pointer is not restarted; only the fill count decides what is read.
   always @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         wrPtr_reg <= {AW{1'b0}};
         fill_reg  <= {(AW+1){1'b0}};
         sum_reg   <= {SW{1'b0}};
      end
      else if (wrAvg)
      begin
         fill_reg <= {(AW+1){1'b0}};
         sum_reg  <= {SW{1'b0}};
      end
      else if (loopTick)
      begin
         wrPtr_reg <= wrPtr_reg + {{(AW-1){1'b0}}, 1'b1};
         if (fill_reg < winSize)
         begin
            fill_reg <= fill_reg + {{AW{1'b0}}, 1'b1};
            sum_reg  <= sum_reg + newExt;
         end
         else
            sum_reg <= sum_reg + newExt - oldExt; // [R20]
      end
   end

   // ==========================================================================
   // Reference choice and holdover state
   // ==========================================================================
   wire activeValid = activeRefSecond ? refValid[1] : refValid[0];
   wire otherValid  = activeRefSecond ? refValid[0] : refValid[1];
   reg  refNext;
   reg  holdNext;

   // Precedence: manual override, then automatic switching, then the select pin.
   // Automatic switching moves only to a valid reference and ignores the select pin.
   // With neither enabled the active input follows the select pin on every clock.
   always @*
   begin
      refNext = activeRefSecond;
      if (override_reg[`RSH_OVR_REF_EN_BIT])
         refNext = override_reg[`RSH_OVR_REF_SEL_BIT]; // [R6] [R7]
      else if (autoPolicy_reg[`RSH_AUTO_SELECT_BIT])
      begin
         if (!activeValid && otherValid)
            refNext = ~activeRefSecond; // [R2]
      end
      else
         refNext = input_choice_pin;
   end

   // Precedence: manual override, then the holdover pin, then permitted automatic
   // entry and exit. Entry and an automatic switch can fall in one cycle; with recovery
   // allowed the loop then leaves holdover again one cycle later.
   always @*
   begin
      holdNext = holdoverActive;
      if (override_reg[`RSH_OVR_HOLD_EN_BIT])
         holdNext = override_reg[`RSH_OVR_HOLD_BIT]; // [R8] [R9]
      else if (holdoverPin)
         holdNext = ST_HOLD;
      else
      begin
         case (holdoverActive)
            ST_TRACK:
               if (autoPolicy_reg[`RSH_AUTO_HOLD_BIT] && !activeValid)
                  holdNext = ST_HOLD; // [R4]
            ST_HOLD:
               if (autoPolicy_reg[`RSH_AUTO_RECOVER_BIT] && activeValid)
                  holdNext = ST_TRACK; // [R3]
            default: holdNext = ST_TRACK;
         endcase
      end
   end

   always @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         activeRefSecond <= 1'b0;
         holdoverActive  <= ST_TRACK;
         heldTuningWord  <= {TW_W{1'b0}};
      end
      else
      begin
         activeRefSecond <= refNext;
         holdoverActive  <= holdNext;
         // The held word is captured only on the entry edge, so it stays fixed for the
         // whole holdover however the live word or the average moves on.
         if (holdoverActive == ST_TRACK && holdNext == ST_HOLD)
         begin
            if (autoPolicy_reg[`RSH_AUTO_AVG_WORD_BIT])
               heldTuningWord <= avgWord; // [R1]
            else
               heldTuningWord <= tuning_word; // [R1]
         end
      end
   end

endmodule // rsh_ref_holdover_ctrl

/* rtl/rsh_consts.vh */
// Constants for the reference selector and holdover controller.
// Assumes inclusion by bare name from the controller module only.
`ifndef RSH_CONSTS_VH
`define RSH_CONSTS_VH

// Register offsets.
`define RSH_OFS_AUTO_POLICY   16'h01C0
`define RSH_OFS_OVERRIDE      16'h01C1
`define RSH_OFS_AVG_WINDOW    16'h01C2
`define RSH_OFS_REVALIDATION  16'h01C3
`define RSH_OFS_LIVE_STATUS   16'h0300
`define RSH_OFS_REF_STATUS    16'h0301

// Automatic policy control fields.
`define RSH_AUTO_AVG_WORD_BIT 4
`define RSH_AUTO_SELECT_BIT   2
`define RSH_AUTO_RECOVER_BIT  1
`define RSH_AUTO_HOLD_BIT     0

// Manual override control fields.
`define RSH_OVR_LINE_CARD_BIT 4
`define RSH_OVR_REF_EN_BIT    3
`define RSH_OVR_REF_SEL_BIT   2
`define RSH_OVR_HOLD_EN_BIT   1
`define RSH_OVR_HOLD_BIT      0

// Field widths.
`define RSH_AVG_SIZE_W        4
`define RSH_TIMER_W           5

// Live status and reference status fields.
`define RSH_STAT_REF_BIT      3
`define RSH_STAT_HOLD_BIT     2
`define RSH_STAT_VALID_A_BIT  6
`define RSH_STAT_VALID_B_BIT  2

// Reset values.
`define RSH_RST_AUTO_POLICY   8'h00
`define RSH_RST_OVERRIDE      8'h00
`define RSH_RST_AVG_WINDOW    8'h00
`define RSH_RST_REVALIDATION  8'h00

`endif

/* verification/rsh_ref_holdover_props.sv */
// Port checker for the reference selector and holdover controller.
// Assumes a bind onto the controller; it shadows two registers from the bus.
`timescale 1ns/100ps
// ==========
// Checker
module rsh_ref_holdover_props
#(
   parameter TW_W = 48
)
(
   input wire            clock,
   input wire            rst_b,
   input wire [15:0]     regAddr,
   input wire [7:0]      regWrData,
   input wire            regWr,
   input wire            input_choice_pin,
   input wire            holdoverPin,
   input wire [TW_W-1:0] tuning_word,
   input wire            first_reference_lost_event,
   input wire            activeRefSecond,
   input wire            holdoverActive,
   input wire            lineCardMode,
   input wire [TW_W-1:0] heldTuningWord,
   input wire            firstRefValid
);
   reg [4:0] ovr_reg;
   reg [4:0] auto_reg;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);
   always @(posedge clock or negedge rst_b)
      if (!rst_b)
      begin
         ovr_reg  <= 5'h00;
         auto_reg <= 5'h00;
      end
      else if (regWr)
      begin
         if (regAddr == 16'h01C1) ovr_reg <= regWrData[4:0];
         if (regAddr == 16'h01C0) auto_reg <= regWrData[4:0];
      end
   sequence s_lost;
      first_reference_lost_event;
   endsequence
   property p_ref_ovr;
      $past(ovr_reg[3]) |-> activeRefSecond == $past(ovr_reg[2]);
   endproperty
   property p_hold_ovr;
      $past(ovr_reg[1]) |-> holdoverActive == $past(ovr_reg[0]);
   endproperty
   property p_line;
      $past(rst_b) |-> lineCardMode == $past(ovr_reg[4]);
   endproperty
   property p_pin;
      $past(rst_b && !ovr_reg[3] && !auto_reg[2])
         |-> activeRefSecond == $past(input_choice_pin);
   endproperty
   property p_no_enter;
      $past(!ovr_reg[1] && !holdoverPin && !auto_reg[0] && !holdoverActive)
         |-> !holdoverActive;
   endproperty
   property p_no_leave;
      $past(!ovr_reg[1] && !holdoverPin && !auto_reg[1] && holdoverActive)
         |-> holdoverActive;
   endproperty
   property p_last_word;
      $rose(holdoverActive) && !$past(auto_reg[4])
         |-> heldTuningWord == $past(tuning_word);
   endproperty
   property p_lost;
      s_lost |-> ##2 !firstRefValid;
   endproperty
   a_ref_ovr: assert property (p_ref_ovr) else $error("ref override");
   a_hold_ovr: assert property (p_hold_ovr) else $error("hold override");
   a_line: assert property (p_line) else $error("line card");
   a_pin: assert property (p_pin) else $error("select pin");
   a_no_enter: assert property (p_no_enter) else $error("entry");
   a_no_leave: assert property (p_no_leave) else $error("exit");
   a_last_word: assert property (p_last_word) else $error("held word");
   a_lost: assert property (p_lost) else $error("valid early");
endmodule // rsh_ref_holdover_props

bind rsh_ref_holdover_ctrl rsh_ref_holdover_props #(.TW_W(TW_W)) u_props
(
   .clock(clock), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData),
   .regWr(regWr), .input_choice_pin(input_choice_pin), .holdoverPin(holdoverPin),
   .tuning_word(tuning_word), .first_reference_lost_event(first_reference_lost_event),
   .activeRefSecond(activeRefSecond), .holdoverActive(holdoverActive),
   .lineCardMode(lineCardMode), .heldTuningWord(heldTuningWord),
   .firstRefValid(firstRefValid)
);

/* verification/rsh_ref_src.sv */
// Model of the two references' monitor events.
// Assumes fault bits: 0 first lost, 1 first range, 2 second lost, 3 second range.
`timescale 1ns/100ps
// ==========
// Reference source
module rsh_ref_src
(
   input  wire       clock,
   input  wire       rst_b,
   input  wire [3:0] fault,
   output reg  [3:0] events
);
   // Both references count as failed until the bench lets them run.
   always @(posedge clock or negedge rst_b)
      if (!rst_b)
         events <= 4'hF;
      else
         events <= fault;
endmodule // rsh_ref_src

/* verification/rsh_ref_holdover_ctrl_tb_top.sv */
// Testbench for the reference selector and holdover controller.
// Assumes the controller and the reference source model are compiled first.
`timescale 1ns/100ps
// ==========
// Bench
module rsh_ref_holdover_ctrl_tb_top;
   reg         clock = 1'b0;
   reg         rst_b = 1'b0;
   reg  [15:0] regAddr = 16'h0000;
   reg  [7:0]  regWrData = 8'h00;
   reg         regWr = 1'b0;
   reg         regRd = 1'b0;
   reg         choicePin = 1'b0;
   reg         holdPin = 1'b0;
   reg  [3:0]  fault = 4'hF;
   reg  [3:0]  divP = 4'h0;
   reg  [47:0] tw = 48'h000000000000;
   wire [7:0]  rdData;
   wire [3:0]  ev;
   wire [47:0] held;
   wire        second_reference, hold, lcm, vA, vB;
   integer     err_count = 0;
   integer     num_checks = 0;
   integer     i, n;
   always #10 clock = ~clock;
   rsh_ref_src u_src (.clock(clock), .rst_b(rst_b), .fault(fault), .events(ev));
   rsh_ref_holdover_ctrl #(.TW_W(48), .AVG_LOG_MAX(4)) u_dut
   (
      .clock(clock), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData),
      .regWr(regWr), .regRd(regRd), .regRdData(rdData),
      .input_choice_pin(choicePin), .holdoverPin(holdPin), .loopDivP(divP),
      .tuning_word(tw), .first_reference_lost_event(ev[0]),
      .first_out_of_range_event(ev[1]), .second_reference_lost_event(ev[2]),
      .second_out_of_range_event(ev[3]), .activeRefSecond(second_reference),
      .holdoverActive(hold), .lineCardMode(lcm), .heldTuningWord(held),
      .firstRefValid(vA), .secondRefValid(vB)
   );
   task chk(input [47:0] s, input [47:0] e);
   begin
      num_checks = num_checks + 1;
      if (s !== e)
      begin
         err_count = err_count + 1;
         $display("mismatch at %0t: seen %h expected %h", $time, s, e);
      end
   end
   endtask
   task give_verdict;
   begin
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   end
   endtask
   task wr(input [15:0] a, input [7:0] d);
   begin
      @(posedge clock);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge clock);
      regWr <= 1'b0;
   end
   endtask
   task rd(input [15:0] a, input [7:0] e);
   begin
      @(posedge clock);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clock);
      regRd <= 1'b0;
      #1 chk(rdData, e);
   end
   endtask
   task step(input integer k);
   begin
      repeat (k) @(posedge clock);
      #1;
   end
   endtask
   initial
   begin
      #200000;
      err_count = err_count + 1;
      give_verdict;
   end
   initial
   begin
      repeat (20) @(posedge clock);
      rst_b <= 1'b1;
      for (i = 0; i < 5; i = i + 1)
      begin
         rd(16'h01C0 + i, 8'h00);
         wr(16'h01C0 + i, 8'hFF);
         rd(16'h01C0 + i, i == 4 ? 8'h00 : (i == 2 ? 8'h0F : 8'h1F));
         chk(lcm, i == 1);
         wr(16'h01C0 + i, 8'h00);
      end
      @(posedge clock);
      fault <= 4'h0;
      for (i = 0; i < 4; i = i + 1)
      begin
         wr(16'h01C3, i == 3 ? 2 : i);
         @(posedge clock);
         fault <= i == 1 ? 4'h2 : 4'h1;
         divP <= i == 3 ? 4'h1 : 4'h0;
         @(posedge clock);
         fault <= 4'h0;
         step(2);
         chk(vA, 1'b0);
         n = 0;
         while (vA !== 1'b1 && n < 100)
         begin
            step(1);
            n = n + 1;
         end
         if (i == 3)
            chk(n == 13 || n == 14, 1'b1);
         else
            chk(n, (2 << i) - 1);
      end
      chk(vB, 1'b1);
      @(posedge clock);
      divP <= 4'h0;
      choicePin <= 1'b1;
      wr(16'h01C1, 8'h08);
      rd(16'h0300, 8'h04);
      wr(16'h01C1, 8'h0C);
      rd(16'h0300, 8'h0C);
      @(posedge clock);
      holdPin <= 1'b1;
      wr(16'h01C1, 8'h02);
      rd(16'h0300, 8'h08);
      @(posedge clock);
      holdPin <= 1'b0;
      tw <= 48'h00000000C0DE;
      wr(16'h01C1, 8'h03);
      rd(16'h0300, 8'h0C);
      chk(held, 48'h00000000C0DE);
      wr(16'h01C1, 8'h02);
      wr(16'h01C2, 8'h02);
      wr(16'h01C0, 8'h10);
      tw <= 48'h000012345678;
      step(12);
      wr(16'h01C1, 8'h03);
      step(3);
      chk(held, 48'h000012345678);
      @(posedge clock);
      choicePin <= 1'b0;
      wr(16'h01C1, 8'h00);
      wr(16'h01C0, 8'h07);
      fault <= 4'h1;
      step(4);
      chk({second_reference, hold}, 2'b10);
      @(posedge clock);
      fault <= 4'h5;
      step(4);
      chk(hold, 1'b1);
      @(posedge clock);
      fault <= 4'h0;
      step(14);
      chk(hold, 1'b0);
      wr(16'h01C0, 8'h01);
      fault <= 4'hF;
      step(4);
      @(posedge clock);
      fault <= 4'h0;
      step(14);
      chk({second_reference, hold}, 2'b01);
      give_verdict;
   end
endmodule // rsh_ref_holdover_ctrl_tb_top
